//--- design/bmmd_defs.vh
// Purpose: Constants for the boot memory map decoder.
// Assumes: Byte addresses of 32 bits on one shared processor bus.
// Notes: Region windows, array sizes, flash geometry, config registers and checksum extents.
`ifndef BMMD_DEFS_VH
`define BMMD_DEFS_VH
`define BMMD_AW 32
`define BMMD_DW 32
// Reset map.
`define BMMD_RST_ROM_BASE 32'h0000_0000
`define BMMD_RST_ROM_LAST 32'h0000_ffff
`define BMMD_RST_PF_BASE 32'h0001_0000
`define BMMD_RST_PF_LAST 32'h0001_7fff
// Normal map.
`define BMMD_NRM_PF_BASE 32'h0000_0000
`define BMMD_NRM_PF_LAST 32'h0000_7fff
`define BMMD_NRM_ROM_BASE 32'h0001_0000
`define BMMD_NRM_ROM_LAST 32'h0001_0fff
// Windows common to both maps.
`define BMMD_DF_BASE 32'h0001_8800
`define BMMD_DF_LAST 32'h0001_8fff
`define BMMD_RAM_BASE 32'h0001_9000
`define BMMD_RAM_LAST 32'h0001_9fff
// Peripheral windows: 256 bytes each.
`define BMMD_PERI_LO 32'h0002_0000
`define BMMD_PERI_HI 32'h000e_0000
`define BMMD_PERI_OFS_W 8
`define BMMD_SYS_BASE 32'hfff7_0000
`define BMMD_PERI_SEL_W 16
// Array word address widths.
`define BMMD_ROM_AW 10
`define BMMD_PF_AW 13
`define BMMD_DF_AW 9
`define BMMD_RAM_AW 10
// Flash erase geometry in words.
`define BMMD_PF_PAGE_W 8
`define BMMD_DF_PAGE_W 3
// Configuration window and its registers.
`define BMMD_CFG_BASE 32'hffff_fe00
`define BMMD_CFG_MAP 8'h00
`define BMMD_CFG_SIZE 8'h04
`define BMMD_SIZE_MIN 5'h0a
`define BMMD_SIZE_MAX 5'h18
`define BMMD_SIZE_RST 5'h0f
// Checksum extents in words.
`define BMMD_CK_SHORT 13'h01ff
`define BMMD_CK_FULL 13'h1fff
`endif

//--- design/bmmd_window.v
// Purpose: One address window comparator.
// Assumes: Base and last are inclusive byte addresses.
// Notes: Reused for the ROM, program flash, data flash and RAM windows.
`default_nettype none
module bmmd_window (
  input wire [31:0] addr,
  input wire [31:0] base,
  input wire [31:0] last,
  output wire hit
);
  // Inclusive compare keeps aliasing decisions in the caller.
  assign hit = (addr >= base) && (addr <= last);
endmodule // bmmd_window
`default_nettype wire

//--- design/bmmd_decoder.v
// Purpose: Address decode, boot remap and boot checksum sequencer.
// Assumes: One bus master, single-cycle requests held until ready.
// Notes: Checksum engine reads program flash words through pf_rdata.
// What this block does
// - All memories and peripherals share one bus and one linear address space.
// - After reset, program flash sits at 0x0001_0000 to 0x0001_7fff.
// - After reset, 4K boot ROM aliases sixteen times across the low 64K.
// - Data flash and RAM keep their windows in both maps.
// - Boot code switches to normal map; flash moves to zero, ROM upward.
// - Peripherals decode 256-byte windows at 64K bases, system blocks near top.
// - Program flash is 8K by 32 words with page or mass erase.
// - Data flash is 512 by 32 words with 32-byte pages and ECC.
// - RAM is 1K by 32 words inside its 4K window.
// - Every reset starts execution in the boot ROM, which checksums flash.
// - A valid 2 kB checksum jumps to flash location zero.
// - Otherwise a valid 32 kB checksum also jumps to flash location zero.
// - When both checksums fail the ROM stays in control for host commands.
// - Host commands may read and write any address, flash included.
// - Program flash region size configurable from 1 kB to 16 MB, default at reset.
// - Config accesses add a wait state; writes need privileged mode.
`default_nettype none
`include "bmmd_defs.vh"
module bmmd_decoder (
  input wire sys_clk,
  input wire rst_n,
  input wire bus_req,
  input wire bus_we,
  input wire bus_priv,
  input wire [31:0] bus_addr,
  input wire [31:0] bus_wdata,
  output reg [31:0] bus_rdata,
  output wire bus_ready,
  output wire sel_rom,
  output wire sel_pflash,
  output wire sel_dflash,
  output wire sel_ram,
  output wire sel_cfg,
  output wire [15:0] sel_peri,
  output wire [9:0] rom_word,
  output wire [12:0] pf_word,
  output wire [8:0] df_word,
  output wire [9:0] ram_word,
  output wire [4:0] pf_erase_page,
  output wire [5:0] df_erase_page,
  input wire [31:0] rom_rdata,
  input wire [31:0] pf_rdata,
  input wire [31:0] df_rdata,
  input wire [31:0] ram_rdata,
  input wire [31:0] peri_rdata,
  input wire [31:0] ck_expect_short,
  input wire [31:0] ck_expect_full,
  output reg [12:0] ck_addr,
  output reg normal_map,
  output reg boot_done,
  output reg host_mode
);
  localparam [2:0] ST_INIT = 3'h0;
  localparam [2:0] ST_SHORT = 3'h1;
  localparam [2:0] ST_FULL = 3'h2;
  localparam [2:0] ST_JUMP = 3'h3;
  localparam [2:0] ST_HOST = 3'h4;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [31:0] sum_reg;
  reg [4:0] size_reg;
  reg wait_reg;
  wire [31:0] pf_base;
  wire [31:0] pf_last;
  wire [31:0] rom_base;
  wire [31:0] rom_last;
  wire [31:0] size_bytes;
  wire hit_pf;
  wire hit_rom;
  wire hit_df;
  wire hit_ram;
  wire in_peri;
  wire in_sys;
  wire [31:0] sum_new;
  wire sys_busy;

  // The map bit picks base addresses; the ROM window spans the alias range before the switch.
  assign pf_base = normal_map ? `BMMD_NRM_PF_BASE : `BMMD_RST_PF_BASE;
  assign pf_last = normal_map ? `BMMD_NRM_PF_LAST : `BMMD_RST_PF_LAST;
  assign rom_base = normal_map ? `BMMD_NRM_ROM_BASE : `BMMD_RST_ROM_BASE;
  assign rom_last = normal_map ? `BMMD_NRM_ROM_LAST : `BMMD_RST_ROM_LAST;
  // Configured size caps the program flash window; the excess simply does not decode.
  assign size_bytes = 32'h0000_0001 << size_reg;

  bmmd_window u_pf (.addr(bus_addr), .base(pf_base), .last(pf_last), .hit(hit_pf));
  bmmd_window u_rom (.addr(bus_addr), .base(rom_base), .last(rom_last), .hit(hit_rom));
  bmmd_window u_df (.addr(bus_addr), .base(`BMMD_DF_BASE), .last(`BMMD_DF_LAST),
    .hit(hit_df));
  bmmd_window u_ram (.addr(bus_addr), .base(`BMMD_RAM_BASE), .last(`BMMD_RAM_LAST),
    .hit(hit_ram));

  // Peripheral windows: 64K-aligned bases, only the low 256 bytes answer.
  assign in_peri = (bus_addr >= `BMMD_PERI_LO) && (bus_addr <= (`BMMD_PERI_HI | 32'h0000_00ff))
    && (bus_addr[15:`BMMD_PERI_OFS_W] == 8'h00);
  assign in_sys = (bus_addr[31:16] == `BMMD_SYS_BASE >> 16) && !sel_cfg;

  // A single select is active at a time; all share the same bus.
  assign sel_pflash = bus_req && hit_pf && ((bus_addr - pf_base) < size_bytes);
  assign sel_rom = bus_req && hit_rom;
  assign sel_dflash = bus_req && hit_df;
  assign sel_ram = bus_req && hit_ram;
  assign sel_cfg = bus_req && (bus_addr[31:8] == `BMMD_CFG_BASE >> 8);
  // Sixteen peripheral select bits: 13 power blocks on bits 0-12 plus the group near the top on bit 15.
  assign sel_peri[14:0] = {15{bus_req && in_peri}} & (15'h0001 << (bus_addr[19:16] - 4'h2));
  assign sel_peri[15] = bus_req && in_sys;

  // Low twelve address bits select the ROM word in every alias.
  assign rom_word = bus_addr[11:2];
  assign pf_word = sys_busy ? ck_addr : bus_addr[14:2];
  assign df_word = bus_addr[10:2];
  assign ram_word = bus_addr[11:2];
  // Erase page indices: 1kB pages in program flash, 32-byte pages in data flash.
  assign pf_erase_page = pf_word[12:`BMMD_PF_PAGE_W];
  assign df_erase_page = df_word[8:`BMMD_DF_PAGE_W];

  // Config accesses stall one cycle; the checksum engine also holds off flash reads.
  assign sys_busy = (state_reg == ST_SHORT) || (state_reg == ST_FULL);
  assign bus_ready = bus_req && !(sel_cfg && !wait_reg) && !(sel_pflash && sys_busy);

  // Read data: registered, zero when nothing decodes.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= 32'h0000_0000;
    end else if (bus_ready && !bus_we) begin
      if (sel_rom) begin
        bus_rdata <= rom_rdata;
      end else if (sel_pflash) begin
        bus_rdata <= pf_rdata;
      end else if (sel_dflash) begin
        bus_rdata <= df_rdata;
      end else if (sel_ram) begin
        bus_rdata <= ram_rdata;
      end else if (sel_cfg) begin
        bus_rdata <= (bus_addr[7:0] == `BMMD_CFG_SIZE) ? {27'h0, size_reg} :
          {31'h0, normal_map};
      end else if (|sel_peri) begin
        bus_rdata <= peri_rdata;
      end else begin
        bus_rdata <= 32'h0000_0000;
      end
    end
  end

  // Config registers: the wait flag gives the one extra cycle; user-mode writes are dropped.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg <= 1'b0;
      normal_map <= 1'b0;
      size_reg <= `BMMD_SIZE_RST;
    end else begin
      wait_reg <= sel_cfg && !wait_reg;
      if (sel_cfg && wait_reg && bus_we && bus_priv) begin
        if (bus_addr[7:0] == `BMMD_CFG_MAP) begin
          normal_map <= bus_wdata[0];
        end else if (bus_addr[7:0] == `BMMD_CFG_SIZE) begin
          if (bus_wdata[4:0] < `BMMD_SIZE_MIN) begin
            size_reg <= `BMMD_SIZE_MIN;
          end else if (bus_wdata[4:0] > `BMMD_SIZE_MAX) begin
            size_reg <= `BMMD_SIZE_MAX;
          end else begin
            size_reg <= bus_wdata[4:0];
          end
        end
      end
      // The jump switches maps on the same edge that raises boot_done, so flash code never
      // runs under the reset map; being last, it also wins over a clearing write that cycle.
      if ((state_next == ST_JUMP) && (state_reg != ST_JUMP)) begin
        normal_map <= 1'b1;
      end
    end
  end

  assign sum_new = sum_reg + pf_rdata;

  // Boot sequencer: short checksum, full one only if it fails, then jump or stay for the host.
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_INIT: state_next = ST_SHORT;
      ST_SHORT: begin
        if (ck_addr == `BMMD_CK_SHORT) begin
          state_next = (sum_new == ck_expect_short) ? ST_JUMP : ST_FULL;
        end
      end
      ST_FULL: begin
        if (ck_addr == `BMMD_CK_FULL) begin
          state_next = (sum_new == ck_expect_full) ? ST_JUMP : ST_HOST;
        end
      end
      ST_JUMP: state_next = ST_JUMP;
      ST_HOST: state_next = ST_HOST;
      default: state_next = ST_INIT;
    endcase
  end

  // Sequencer registers; the sum restarts when the full pass begins.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_INIT;
      ck_addr <= 13'h0000;
      sum_reg <= 32'h0000_0000;
      boot_done <= 1'b0;
      host_mode <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        ck_addr <= 13'h0000;
        sum_reg <= 32'h0000_0000;
      end else if (sys_busy) begin
        ck_addr <= ck_addr + 13'h0001;
        sum_reg <= sum_new;
      end
      boot_done <= (state_next == ST_JUMP);
      host_mode <= (state_next == ST_HOST);
    end
  end
endmodule // bmmd_decoder
`default_nettype wire

//--- test/bmmd_decoder_monitor.sv
// Purpose: Port-level checks on the boot memory map decoder.
// Assumes: Only the decoder's top-level ports are visible.
// Notes: Array contents are outside this checker; selects, words and flags are.
`default_nettype none
module bmmd_decoder_monitor (
  input wire sys_clk,
  input wire rst_n,
  input wire bus_req,
  input wire bus_we,
  input wire bus_priv,
  input wire [31:0] bus_addr,
  input wire [31:0] bus_rdata,
  input wire bus_ready,
  input wire sel_rom,
  input wire sel_pflash,
  input wire sel_dflash,
  input wire sel_ram,
  input wire sel_cfg,
  input wire [15:0] sel_peri,
  input wire [9:0] rom_word,
  input wire [12:0] pf_word,
  input wire [8:0] df_word,
  input wire [9:0] ram_word,
  input wire [4:0] pf_erase_page,
  input wire [5:0] df_erase_page,
  input wire normal_map,
  input wire boot_done,
  input wire host_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] cyc_reg;
  // Saturating cycle count since reset; the checksum pass cannot end sooner.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_reg <= 10'h0;
    end else if (cyc_reg != 10'h3ff) begin
      cyc_reg <= cyc_reg + 10'h1;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence cfg_start;
    $rose(bus_req) && sel_cfg;
  endsequence
  sequence weak_cfg_wr;
    bus_req && bus_ready && sel_cfg && bus_we && !bus_priv;
  endsequence
  sequence unm_rd;
    bus_req && bus_ready && !bus_we && bus_addr[31:16] == 16'h1 && bus_addr[15:12] >= 4'ha;
  endsequence
  a_rom_alias: assert property (bus_req && !normal_map && bus_addr[31:16] == 16'h0
    |-> sel_rom && rom_word == bus_addr[11:2]) else $error("rom alias miss");
  a_pf_normal: assert property (bus_req && normal_map && bus_addr[31:15] == 17'h0
    |-> sel_pflash && pf_word == bus_addr[14:2]) else $error("flash at zero miss");
  a_df_window: assert property (bus_req && bus_addr[31:11] == 21'h31
    |-> sel_dflash && df_word == bus_addr[10:2]) else $error("data flash miss");
  a_ram_window: assert property (bus_req && bus_addr[31:12] == 20'h19
    |-> sel_ram && ram_word == bus_addr[11:2]) else $error("ram miss");
  a_peri_window: assert property (bus_req && bus_addr[31:20] == 12'h0
    && bus_addr[15:8] == 8'h0 && bus_addr[19:16] >= 4'h2 && bus_addr[19:16] <= 4'he
    |-> sel_peri == (16'h1 << (bus_addr[19:16] - 4'h2))) else $error("peripheral miss");
  a_unmapped_sel: assert property (unm_rd |-> !(sel_rom || sel_pflash || sel_dflash
    || sel_ram || sel_cfg) && sel_peri == 16'h0) else $error("unmapped selected");
  a_unmapped_zero: assert property (unm_rd |=> bus_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_cfg_wait: assert property (cfg_start |-> !bus_ready ##1 bus_ready)
    else $error("config wait state wrong");
  a_cfg_guard: assert property (weak_cfg_wr |=> $stable(normal_map) [*2])
    else $error("user write changed map");
  a_jump_map: assert property ($rose(boot_done) |-> normal_map && !host_mode)
    else $error("jump without normal map");
  a_pf_erase_page: assert property (bus_req && bus_ready && sel_pflash
    |-> pf_erase_page == bus_addr[14:10]) else $error("flash page index wrong");
  a_df_erase_page: assert property (bus_req && sel_dflash
    |-> df_erase_page == bus_addr[10:5]) else $error("data flash page index wrong");
  a_rom_first: assert property (cyc_reg < 10'h1f4
    |-> !boot_done && !normal_map && !host_mode) else $error("left rom too early");
endmodule // bmmd_decoder_monitor
bind bmmd_decoder bmmd_decoder_monitor bmmd_decoder_monitor_inst (.sys_clk, .rst_n, .bus_req,
  .bus_we, .bus_priv, .bus_addr, .bus_rdata, .bus_ready, .sel_rom, .sel_pflash, .sel_dflash,
  .sel_ram, .sel_cfg, .sel_peri, .rom_word, .pf_word, .df_word, .ram_word, .pf_erase_page,
  .df_erase_page, .normal_map, .boot_done, .host_mode);
`default_nettype wire

//--- test/bmmd_cpu_model.sv
// Purpose: Processor core model mastering the shared bus.
// Assumes: Requests change after a rising edge and hold until ready.
// Notes: A released address shows its inverse so stale values never match.
`default_nettype none
module bmmd_cpu_model (
  input wire logic sys_clk,
  input wire logic bus_ready,
  input wire logic [31:0] bus_rdata,
  output var logic bus_req,
  output var logic bus_we,
  output var logic bus_priv,
  output var logic [31:0] bus_addr,
  output var logic [31:0] bus_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero.
  initial begin
    bus_req = 1'b0;
    bus_we = 1'b0;
    bus_priv = 1'b0;
    bus_addr = 32'hffffffff;
    bus_wdata = 32'h0;
  end
  // One access on the single linear bus; a stall is waited out with a bound.
  task access(input logic [31:0] a, wd, input logic we, pr, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge sys_clk);
    bus_req <= 1'b1;
    bus_addr <= a;
    bus_wdata <= wd;
    bus_we <= we;
    bus_priv <= pr;
    @(negedge sys_clk);
    while (bus_ready !== 1'b1 && n < 20000) begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    bus_req <= 1'b0;
    bus_addr <= ~a;
    bus_wdata <= ~wd;
    @(negedge sys_clk);
    rd = bus_rdata;
  endtask
endmodule // bmmd_cpu_model
`default_nettype wire

//--- test/tb.sv
// Purpose: Self-checking bench for the boot memory map decoder.
// Assumes: Arrays are modelled as fixed functions of their word address.
// Notes: Flash words are a random multiple of the word index, so sums are known.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rst_n;
  logic [31:0] k, ck_expect_short, ck_expect_full;
  int seed, checked, miscompares;
  wire bus_req, bus_we, bus_priv, bus_ready, sel_rom, sel_pflash, sel_dflash, sel_ram, sel_cfg;
  wire normal_map, boot_done, host_mode;
  wire [31:0] bus_addr, bus_wdata, bus_rdata, rom_rdata, pf_rdata, df_rdata, ram_rdata, peri_rdata;
  wire [15:0] sel_peri;
  wire [12:0] pf_word, ck_addr;
  wire [9:0] rom_word, ram_word;
  wire [8:0] df_word;
  // Array contents follow the word address so any misrouted word shows.
  assign rom_rdata = {22'h0, rom_word} | 32'h5a000000;
  assign pf_rdata = k * {19'h0, pf_word};
  assign df_rdata = {23'h0, df_word} | 32'hd0000000;
  assign ram_rdata = {22'h0, ram_word} | 32'h3a000000;
  assign peri_rdata = {16'h0, sel_peri};
  bmmd_decoder bmmd_decoder_inst (.sys_clk, .rst_n, .bus_req, .bus_we, .bus_priv, .bus_addr,
    .bus_wdata, .bus_rdata, .bus_ready, .sel_rom, .sel_pflash, .sel_dflash, .sel_ram, .sel_cfg,
    .sel_peri, .rom_word, .pf_word, .df_word, .ram_word, .pf_erase_page(), .df_erase_page(),
    .rom_rdata, .pf_rdata, .df_rdata, .ram_rdata, .peri_rdata, .ck_expect_short,
    .ck_expect_full, .ck_addr, .normal_map, .boot_done, .host_mode);
  bmmd_cpu_model bmmd_cpu_model_inst (.sys_clk, .bus_ready, .bus_rdata, .bus_req, .bus_we,
    .bus_priv, .bus_addr, .bus_wdata);
  // Free-running 10 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task check(input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task rd(input logic [31:0] a, exp);
    logic [31:0] r;
    bmmd_cpu_model_inst.access(a, 32'h0, 1'b0, 1'b0, r);
    check(r, exp);
  endtask
  task wr(input logic [31:0] a, wd, input logic pr);
    logic [31:0] r;
    bmmd_cpu_model_inst.access(a, wd, 1'b1, pr, r);
    repeat (2) @(negedge sys_clk);
  endtask
  task boot(input logic [31:0] s, f);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    ck_expect_short <= s;
    ck_expect_full <= f;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask
  task wait_boot(input int n);
    for (int i = 0; i < n && boot_done !== 1'b1 && host_mode !== 1'b1; i++) @(negedge sys_clk);
  endtask
  task tally_and_finish;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Three boots take about 18000 cycles; allow two thirds again (30000 cycles) before giving up.
  initial begin
    #3000000;
    miscompares++;
    tally_and_finish();
  end
  // Short sum of 0..511 is 0x1ff00 and full sum of 0..8191 is 0x1fff000, times k.
  initial begin
    logic [31:0] a;
    seed = 32'hc511;
    k = $random(seed);
    rst_n = 1'b0;
    ck_expect_short = 32'h0;
    ck_expect_full = 32'h0;
    boot(k * 32'h1ff00, 32'h0);
    for (int i = 0; i < 4; i++) begin
      a = {16'h0, 14'($random(seed)), 2'b00};
      rd(a, {22'h0, a[11:2]} | 32'h5a000000);
    end
    check({29'h0, host_mode, boot_done, normal_map}, 32'h0);
    wait_boot(700);
    check({29'h0, host_mode, boot_done, normal_map}, 32'h3);
    a = {17'h0, 13'($random(seed)), 2'b00};
    rd(a, k * {19'h0, a[14:2]});
    rd(32'h00010008, 32'h5a000002);
    rd(32'h00018804, 32'hd0000001);
    rd(32'h00019ffc, 32'h3a0003ff);
    rd(32'h00050010, 32'h00000008);
    rd(32'h0001a000, 32'h0);
    $display("test short checksum done");
    boot(~(k * 32'h1ff00), k * 32'h1fff000);
    repeat (600) @(negedge sys_clk);
    check({29'h0, host_mode, boot_done, normal_map}, 32'h0);
    wait_boot(9000);
    check({29'h0, host_mode, boot_done, normal_map}, 32'h3);
    $display("test full checksum done");
    boot(~(k * 32'h1ff00), ~(k * 32'h1fff000));
    wait_boot(9000);
    check({29'h0, host_mode, boot_done, normal_map}, 32'h4);
    rd(32'h00010010, k * 32'h4);
    // Size writes clamp to the legal range; a 1 kB flash window leaves the rest unmapped.
    wr(32'hfffffe04, 32'h1f, 1'b1);
    rd(32'hfffffe04, 32'h18);
    wr(32'hfffffe04, 32'h3, 1'b1);
    rd(32'hfffffe04, 32'ha);
    rd(32'h000103fc, k * 32'hff);
    rd(32'h00010400, 32'h0);
    wr(32'hfffffe00, 32'h1, 1'b0);
    check({29'h0, host_mode, boot_done, normal_map}, 32'h4);
    wr(32'hfffffe00, 32'h1, 1'b1);
    check({29'h0, host_mode, boot_done, normal_map}, 32'h5);
    rd(32'hfffffe00, 32'h1);
    rd(32'h00000010, k * 32'h4);
    $display("test host mode done");
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
